// file: hdl/ofd_cond_eval.sv
/*
 Combinational condition evaluator of the operand field decoder.
 Assumes carry and zero flags stable in the cycle they are read.
*/
module ofd_cond_eval
   import ofd_pkg::*;
(
   input  wire logic [3:0] cond_code,
   input  wire logic       carry_flag,
   input  wire logic       zero_flag,
   output logic            cond_true,
   output logic            cond_known
);
   always_comb begin
      cond_true  = 1'b0;
      cond_known = 1'b1;
      case (cond_code)
         OFD_CC_NEVER:  cond_true = 1'b0;
         OFD_CC_ALWAYS: cond_true = 1'b1;
         OFD_CC_ZERO:   cond_true = zero_flag;
         OFD_CC_NZERO:  cond_true = ~zero_flag;
         OFD_CC_CARRY:  cond_true = carry_flag;
         OFD_CC_NCARRY: cond_true = ~carry_flag;
         default:       cond_known = 1'b0;
      endcase
   end
endmodule

// file: hdl/ofd_decoder.sv
/*
 Operand field decoder: register field, condition field and control
 register selector decode, reached over an Avalon-MM slave.
 Assumes one clock, synchronous active-low reset, a well-behaved master.
*/
// The address map and register access over Avalon-MM were decided locally.
// Operation
// - Word code selects word n; byte codes 0-7 high, 8-15 low bytes.
// - Pair uses even code; quad valid only for 0, 4, 8, 12.
// - Condition 0000 never true, 1000 always true.
// - Condition 0110 true on zero set, 1110 on zero clear.
// - Condition 0111 true on carry set, 1111 on carry clear.
// - Nonsegmented: status area pointer maps to its offset register.
// - Nonsegmented: normal stack pointer maps to its offset register.
// - Control selector distinguishes the nine control register names.
module ofd_decoder
   import ofd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic             avs_response_err,
   output logic             cond_true
);
   logic [31:0] oper_q;
   logic [31:0] ctl_q;
   logic [31:0] rdata_q;
   logic        err_q;
   ofd_bus_e    bus_q;
   ofd_bus_e    bus_d;

   // Byte-lane merge, used for both writable registers
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Operand fields and the nonsegmented mode bit
   wire logic [3:0] reg_fld  = oper_q[OFD_OP_REG_LSB +: 4];
   wire logic [3:0] cc_fld   = oper_q[OFD_OP_CC_LSB +: 4];
   wire logic [3:0] cr_fld   = oper_q[OFD_OP_CR_LSB +: 4];
   wire logic [6:0] flg_fld  = oper_q[OFD_OP_FLG_LSB +: 7];
   wire logic       nonseg   = ctl_q[OFD_CTL_NONSEG];

   // Register field decode
   wire logic [3:0] word_idx      = reg_fld;
   wire logic       byte_is_low   = reg_fld[3];
   wire logic [2:0] byte_word     = reg_fld[2:0];
   wire logic [3:0] pair_base     = {reg_fld[3:1], 1'b0};
   wire logic       pair_valid    = ~reg_fld[0];
   wire logic [3:0] quad_base     = {reg_fld[3:2], 2'b00};
   wire logic       quad_valid    = (reg_fld[1:0] == 2'b00);

   // Condition evaluation, combinational
   logic cond_known;
   ofd_cond_eval u_cond (
      .cond_code  (cc_fld),
      .carry_flag (ctl_q[OFD_CTL_CARRY]),
      .zero_flag  (ctl_q[OFD_CTL_ZERO]),
      .cond_true  (cond_true),
      .cond_known (cond_known)
   );

   // Control register selector
   wire logic       cr_valid = (cr_fld <= OFD_CR_NSP_OFF);
   wire logic [3:0] cr_eff   =
      (nonseg && cr_fld == OFD_CR_STATUS_AREA_POINTER) ? OFD_CR_STATUS_AREA_POINTER_OFF :
      (nonseg && cr_fld == OFD_CR_NSP)  ? OFD_CR_NSP_OFF  :
      cr_fld;

   // Flag operand check: D and H are refused
   wire logic flg_illegal =
      flg_fld[OFD_FLG_D] | flg_fld[OFD_FLG_H];

   // Packed decode results, read only
   wire logic [31:0] dec_word = {7'h00, flg_illegal, cond_known,
                                 cr_valid, cr_eff, quad_valid,
                                 quad_base, pair_valid, pair_base,
                                 byte_is_low, byte_word, word_idx};

   // Bus decode
   wire logic hit_oper = (avs_address == OFD_ADDR_OPER);
   wire logic hit_dec  = (avs_address == OFD_ADDR_DEC);
   wire logic hit_ctl  = (avs_address == OFD_ADDR_CTL);
   wire logic hit_id   = (avs_address == OFD_ADDR_ID);
   wire logic req      = avs_read | avs_write;
   wire logic take     = req && (bus_q == OFD_ACK);
   wire logic [31:0] rmux =
      hit_oper ? oper_q :
      hit_dec  ? {dec_word[31:1], dec_word[0]} :
      hit_ctl  ? ctl_q :
      hit_id   ? OFD_ID_VALUE : 32'h0000_0000;
   wire logic unmapped = ~(hit_oper | hit_dec | hit_ctl | hit_id);

   // One wait cycle per access, answer on the second edge
   always_comb begin
      bus_d = bus_q;
      case (bus_q)
         OFD_IDLE: if (req) bus_d = OFD_ACK;
         OFD_ACK:  bus_d = OFD_IDLE;
         default:  bus_d = OFD_IDLE;
      endcase
   end
   assign avs_waitrequest = req && (bus_q != OFD_ACK);
   assign avs_readdata    = rdata_q;
   assign avs_response_err = err_q;

   // Handshake state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bus_q <= OFD_IDLE;
      end else begin
         bus_q <= bus_d;
      end
   end

   // Writes land at the edge where waitrequest is low
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         oper_q <= OFD_OPER_RST;
         ctl_q  <= OFD_CTL_RST;
      end else if (avs_write && take) begin
         if (hit_oper) oper_q <= merge(oper_q, avs_writedata, avs_byteenable);
         if (hit_ctl)  ctl_q  <= merge(ctl_q, avs_writedata, avs_byteenable);
      end
   end

   // Read data and error latched at the request edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_q <= 32'h0000_0000;
         err_q   <= 1'b0;
      end else begin
         rdata_q <= (avs_read && bus_q == OFD_IDLE) ? rmux : rdata_q;
         err_q   <= (req && bus_q == OFD_IDLE) ? unmapped : err_q;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Condition evaluator against the status flags
   never_true_a: assert property (
      cc_fld == OFD_CC_NEVER |-> !cond_true)
      else $error("never condition reported true");
   always_true_a: assert property (
      cc_fld == OFD_CC_ALWAYS |-> cond_true)
      else $error("always condition reported false");
   zero_cond_a: assert property (
      (cc_fld == OFD_CC_ZERO |-> cond_true == ctl_q[OFD_CTL_ZERO]) and
      (cc_fld == OFD_CC_NZERO |-> cond_true != ctl_q[OFD_CTL_ZERO]))
      else $error("zero condition wrong");
   carry_cond_a: assert property (
      (cc_fld == OFD_CC_CARRY |-> cond_true == ctl_q[OFD_CTL_CARRY]) and
      (cc_fld == OFD_CC_NCARRY |-> cond_true != ctl_q[OFD_CTL_CARRY]))
      else $error("carry condition wrong");

   // Pointer folding in the nonsegmented variant, none in the segmented one
   status_area_pointer_fold_a: assert property (
      nonseg && cr_fld == OFD_CR_STATUS_AREA_POINTER |-> cr_eff == OFD_CR_STATUS_AREA_POINTER_OFF)
      else $error("status area pointer not folded");
   nsp_fold_a: assert property (
      nonseg && cr_fld == OFD_CR_NSP |-> cr_eff == OFD_CR_NSP_OFF)
      else $error("stack pointer not folded");
   seg_keep_a: assert property (
      !nonseg |-> cr_eff == cr_fld)
      else $error("segmented selector altered");

   // Register field decode and flag operand check
   byte_half_a: assert property (
      byte_is_low == (reg_fld >= 4'h8) &&
      {1'b0, byte_word} == (reg_fld & 4'h7))
      else $error("byte half decode wrong");
   quad_code_a: assert property (
      quad_valid |-> (reg_fld == 4'h0 || reg_fld == 4'h4 ||
                      reg_fld == 4'h8 || reg_fld == 4'hc))
      else $error("quad accepted on bad code");
   pair_even_a: assert property (
      pair_valid |-> !reg_fld[0] && pair_base == reg_fld)
      else $error("pair accepted on odd code");
   flag_refuse_a: assert property (
      flg_fld[OFD_FLG_D] || flg_fld[OFD_FLG_H] |-> flg_illegal)
      else $error("decimal-adjust or half-carry flag accepted");

   // Bus handshake, register hold and unknown condition
   bus_answer_a: assert property (
      req && bus_q == OFD_IDLE |->
      avs_waitrequest ##1 (!req || !avs_waitrequest))
      else $error("bus answer late");
   oper_hold_a: assert property (
      !(take && avs_write && hit_oper) |=> $stable(oper_q))
      else $error("operand register changed without a write");
   ctl_hold_a: assert property (
      !(take && avs_write && hit_ctl) |=> $stable(ctl_q))
      else $error("control register changed without a write");
   rdata_hold_a: assert property (
      !(avs_read && bus_q == OFD_IDLE) |=> $stable(avs_readdata))
      else $error("read data changed outside a read");
   unknown_cond_a: assert property (
      !cond_known |-> !cond_true)
      else $error("unknown condition reported true");

   // Main scenarios
   nonseg_cov: cover property (nonseg && cr_fld == OFD_CR_STATUS_AREA_POINTER);
   cond_cov: cover property (cc_fld == OFD_CC_ZERO && cond_true);
   read_cov: cover property (avs_read && !avs_waitrequest);
   bad_quad_cov: cover property (!quad_valid && !pair_valid);
   write_cov: cover property (take && avs_write && hit_ctl);
endmodule

// file: hdl/ofd_pkg.sv
/*
 Constants for the operand field decoder: register field codes,
 condition codes, control register selectors and the register map.
 Assumes a single clock domain and a 32-bit Avalon-MM slave port.
*/
package ofd_pkg;
   localparam logic [3:0] OFD_CC_NEVER   = 4'h0;
   localparam logic [3:0] OFD_CC_ALWAYS  = 4'h8;
   localparam logic [3:0] OFD_CC_ZERO    = 4'h6;
   localparam logic [3:0] OFD_CC_NZERO   = 4'he;
   localparam logic [3:0] OFD_CC_CARRY   = 4'h7;
   localparam logic [3:0] OFD_CC_NCARRY  = 4'hf;

   // Register map, byte addresses
   localparam logic [3:0] OFD_ADDR_OPER  = 4'h0;
   localparam logic [3:0] OFD_ADDR_DEC   = 4'h4;
   localparam logic [3:0] OFD_ADDR_CTL   = 4'h8;
   localparam logic [3:0] OFD_ADDR_ID    = 4'hc;
   localparam logic [31:0] OFD_ID_VALUE  = 32'h0000_0a5c; // Arbitrary
   localparam logic [31:0] OFD_OPER_RST  = 32'h0000_0000;
   localparam logic [31:0] OFD_CTL_RST   = 32'h0000_0000;

   // Operand register fields
   localparam int OFD_OP_REG_LSB  = 0;   // 4-bit register field
   localparam int OFD_OP_CC_LSB   = 4;   // 4-bit condition field
   localparam int OFD_OP_CR_LSB   = 8;   // 4-bit control register code
   localparam int OFD_OP_FLG_LSB  = 12;  // 7-bit flag mask C Z S P V D H
   localparam int OFD_CTL_CARRY   = 0;
   localparam int OFD_CTL_ZERO    = 1;
   localparam int OFD_CTL_NONSEG  = 2;

   typedef enum logic [3:0] {
      OFD_CR_FLAGS     = 4'h0,
      OFD_CR_FCW       = 4'h1,
      OFD_CR_REFRESH   = 4'h2,
      OFD_CR_STATUS_AREA_POINTER      = 4'h3,
      OFD_CR_STATUS_AREA_POINTER_SEG  = 4'h4,
      OFD_CR_STATUS_AREA_POINTER_OFF  = 4'h5,
      OFD_CR_NSP       = 4'h6,
      OFD_CR_NSP_SEG   = 4'h7,
      OFD_CR_NSP_OFF   = 4'h8
   } ofd_cr_e;

   // Flag mask bit positions
   localparam int OFD_FLG_D = 5;
   localparam int OFD_FLG_H = 6;

   typedef enum logic [1:0] {
      OFD_IDLE = 2'b00,
      OFD_ACK  = 2'b01
   } ofd_bus_e;
endpackage

// file: testbench/ofd_exec_model.sv
/*
 Execution unit model: Avalon-MM master issuing decoder accesses.
 Assumes the decoder lowers waitrequest once per request.
*/
module ofd_exec_model
   import ofd_pkg::*;
(
   input  wire logic        clk,
   output logic [3:0]       avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic [31:0]      avs_writedata,
   output logic [3:0]       avs_byteenable,
   input  wire logic        avs_waitrequest
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
   end
   task automatic xfer(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] be);
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      avs_byteenable <= be;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // Flag operands name no D or H unless asked to misbehave
   function automatic logic [31:0] mk_oper(input logic [18:0] f,
                                           input logic bad);
      return bad ? {13'h0, f} : {13'h0, f & 19'h1_ffff};
   endfunction
endmodule

// file: testbench/tb_operand_field_decoder.sv
/*
 Self-checking bench of the operand field decoder.
 Assumes the execution unit model drives the register bus.
*/
module tb_operand_field_decoder
   import ofd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, wreq, ack, err, cond, err_w;
   logic [3:0] adr, be;
   logic [31:0] wd, rdd, oper_m, ctl_m, v;
   logic [33:0] exp_q[$];
   int fail_count, total_checks, seed;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   ofd_exec_model u_exec (.clk(clk), .avs_address(adr), .avs_read(ack),
      .avs_write(wreq), .avs_writedata(wd), .avs_byteenable(be),
      .avs_waitrequest(err_w));
   ofd_decoder dut (.clk(clk), .rst_n(rst_n), .avs_address(adr),
      .avs_read(ack), .avs_write(wreq), .avs_writedata(wd),
      .avs_byteenable(be), .avs_readdata(rdd), .avs_waitrequest(err_w),
      .avs_response_err(err), .cond_true(cond));
   function automatic logic cond_of(input logic [3:0] cc, input logic c, z);
      case (cc)
         4'h8: return 1'b1;
         4'h6: return z;
         4'he: return !z;
         4'h7: return c;
         4'hf: return !c;
         default: return 1'b0;
      endcase
   endfunction
   function automatic logic [31:0] dec_of(input logic [31:0] o,
                                          input logic ns);
      logic [3:0] r, cc, cr, ef;
      r = o[3:0];
      cc = o[7:4];
      cr = o[11:8];
      ef = (ns && cr == 4'h3) ? 4'h5 : (ns && cr == 4'h6) ? 4'h8 : cr;
      return {7'h0, |o[18:17], cc inside {4'h0, 4'h8, 4'h6, 4'he, 4'h7,
              4'hf}, cr <= 4'h8, ef, r[1:0] == 2'b00, r[3:2], 2'b00,
              !r[0], r[3:1], 1'b0, r[3], r[2:0], r};
   endfunction
   task automatic check(input string n, input logic [33:0] s, e);
      total_checks++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] d,
                     input logic e);
      exp_q.push_back({cond_of(oper_m[7:4], ctl_m[0], ctl_m[1]), e, d});
      u_exec.xfer(1'b0, a, 32'h0, 4'hf);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b);
      logic [31:0] m;
      m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
      if (a == OFD_ADDR_OPER)
         oper_m = ((oper_m & ~m) | (d & m)) & 32'h7ffff;
      if (a == OFD_ADDR_CTL)
         ctl_m = ((ctl_m & ~m) | (d & m)) & 32'h7;
      u_exec.xfer(1'b1, a, d, b);
   endtask
   always @(posedge clk)
      if (ack === 1'b1 && err_w === 1'b0)
         check("read", {cond, err, rdd}, exp_q.pop_front());
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #80000;
      fail_count++;
      complete_run;
   end
   initial begin
      rst_n = 1'b0;
      seed = 12183;
      oper_m = OFD_OPER_RST;
      ctl_m = OFD_CTL_RST;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd(OFD_ADDR_OPER, OFD_OPER_RST, 1'b0);
      rd(OFD_ADDR_CTL, OFD_CTL_RST, 1'b0);
      rd(OFD_ADDR_ID, OFD_ID_VALUE, 1'b0);
      rd(OFD_ADDR_DEC, dec_of(oper_m, 1'b0), 1'b0);
      $display("test reset done");
      rd(4'h2, 32'h0, 1'b1);
      wr(4'h6, 32'h1234, 4'hf);
      wr(OFD_ADDR_ID, 32'h55, 4'hf);
      wr(OFD_ADDR_DEC, 32'h77, 4'hf);
      rd(OFD_ADDR_ID, OFD_ID_VALUE, 1'b0);
      rd(OFD_ADDR_OPER, oper_m, 1'b0);
      $display("test map done");
      for (int i = 0; i < 128; i++) begin
         v = $random(seed);
         wr(OFD_ADDR_CTL, {29'h0, i[6:4]}, 4'hf);
         wr(OFD_ADDR_OPER, u_exec.mk_oper({v[18:8], i[3:0], v[3:0]},
            v[20]), 4'hf);
         rd(OFD_ADDR_DEC, dec_of(oper_m, ctl_m[2]), 1'b0);
         rd(OFD_ADDR_OPER, oper_m, 1'b0);
      end
      $display("test sweep done");
      wr(OFD_ADDR_OPER, 32'hffff_ffff, 4'h2);
      rd(OFD_ADDR_OPER, oper_m, 1'b0);
      rd(OFD_ADDR_DEC, dec_of(oper_m, ctl_m[2]), 1'b0);
      $display("test lanes done");
      complete_run;
   end
endmodule
